// File: logic/pao_cfg.svh
`ifndef PAO_CFG_SVH
`define PAO_CFG_SVH
// Register indices; the byte address is four times the index.
`define PAO_IDX_PIN 8'h19
`define PAO_IDX_DIR 8'h1a
`define PAO_IDX_LATCH 8'h1b
`define PAO_IDX_CORE 8'h35
`define PAO_DIR_RST 8'h00
`define PAO_LATCH_RST 8'h00
`define PAO_CORE_RST 8'h00
// Writable bits of the core control register (bits 6 to 3).
`define PAO_CORE_MASK 8'h78
`define PAO_PUD_BIT 6
`define PAO_REF_PIN 3
`define PAO_RESP_OK 2'b00
`define PAO_RESP_ERR 2'b10
`endif

// File: logic/pao_pkg.sv
`default_nettype none
package pao_pkg;
  // Per-pin override pairs (toggle has an enable only), one bit per pin in each field.
  typedef struct packed {
    logic [7:0] pull_en;
    logic [7:0] pull_val;
    logic [7:0] dir_en;
    logic [7:0] dir_val;
    logic [7:0] val_en;
    logic [7:0] val_val;
    logic [7:0] tog_en;
    logic [7:0] ie_en;
    logic [7:0] ie_val;
  } pao_ovr_t;
  // Control lines from the serial interface.
  typedef struct packed {
    logic two_wire;
    logic three_wire;
    logic pos_sel;
    logic clock_hold;
    logic toggle_req;
    logic data_out;
    logic sda_low;
    logic start_irq_en;
  } pao_serial_t;
endpackage
`default_nettype wire

// File: logic/pao_port_a.sv
// Overview of operation
// - Three-wire mode drives pin 1 from serial output.
// - Pin 1 input keeps pull-up from latch bit.
// - Global pull-up off bit kills every pull-up.
// - Pins 7-4 input enable overridden by pin-change/analog.
// - Analog reference use disables pin 3 pull/driver.
// - Two-wire pin 2 direction override from hold/latch.
// - Two-wire output value forced zero, pins 0, 2.
// - Two-wire pin 0 direction override from data/latch.
// - Pin 2 input enable override conditions.
// - Pin 0 input enable override conditions.
// - Pin 4 input feeds capture logic.
// - Pin 2 input feeds external interrupt one.
// - Pin n feeds pin-change source n.
// - Direction register read/write, resets to zero.
// - Pin register returns sampled pin levels.
`include "pao_cfg.svh"
`default_nettype none
module pao_port_a
  import pao_pkg::*;
#(
  parameter int AW = 10
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [AW-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [AW-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic [7:0] pad_in,
  output logic [7:0] pad_out,
  output logic [7:0] pad_oe,
  output logic [7:0] pad_pullup,
  input wire pao_serial_t serial_ctrl,
  input wire logic [7:0] pin_change_mask,
  input wire logic pin_change_irq_en,
  input wire logic ext_irq_one_en,
  input wire logic [7:0] analog_digital_off,
  input wire logic analog_ref_active,
  output logic [7:0] pin_change_src,
  output logic capture_input,
  output logic ext_irq_one,
  output logic serial_data_in,
  output logic serial_clock_pin
);

  localparam int IW = AW - 2;

  ////////////////////////////////////////////////////////////////////////////
  logic aw_hold_r, aw_hold_nxt, w_hold_r, w_hold_nxt;
  logic [IW-1:0] waddr_r, waddr_nxt;
  logic [7:0] wdata_r, wdata_nxt;
  logic wlane_r, wlane_nxt;
  logic bvalid_r, bvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt;
  logic rvalid_r, rvalid_nxt;
  logic [1:0] rresp_r, rresp_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic [7:0] dir_r, dir_nxt, latch_r, latch_nxt, core_r, core_nxt;
  logic [IW-1:0] wr_idx, rd_idx;
  logic [7:0] wr_dat;
  logic wr_lane, do_write, wr_hit, rd_hit;
  logic [7:0] s1_r, s2_r, s3_r, stable_r, stable_nxt, agree;
  logic [7:0] dir_c, out_c, pull_c, in_off_c, pin_level, ref_mask;
  logic [7:0] pad_out_r, pad_oe_r, pad_pull_r, pc_src_r;
  logic cap_r, ext_r, sdi_r, sck_r;
  pao_ovr_t ovr;

  assign awready = !aw_hold_r && !bvalid_r;
  assign wready = !w_hold_r && !bvalid_r;
  assign arready = !rvalid_r;
  assign bvalid = bvalid_r;
  assign bresp = bresp_r;
  assign rvalid = rvalid_r;
  assign rresp = rresp_r;
  assign rdata = {24'h000000, rdata_r};

  // Address and data may arrive in either order; each is parked until its mate comes.
  assign wr_idx = aw_hold_r ? waddr_r : awaddr[AW-1:2];
  assign wr_dat = w_hold_r ? wdata_r : wdata[7:0];
  assign wr_lane = w_hold_r ? wlane_r : wstrb[0];
  assign do_write = (aw_hold_r || (awvalid && awready)) && (w_hold_r || (wvalid && wready));
  assign wr_hit = (wr_idx == IW'(`PAO_IDX_PIN)) || (wr_idx == IW'(`PAO_IDX_DIR)) ||
                  (wr_idx == IW'(`PAO_IDX_LATCH)) || (wr_idx == IW'(`PAO_IDX_CORE));
  assign rd_idx = araddr[AW-1:2];
  assign rd_hit = (rd_idx == IW'(`PAO_IDX_PIN)) || (rd_idx == IW'(`PAO_IDX_DIR)) ||
                  (rd_idx == IW'(`PAO_IDX_LATCH)) || (rd_idx == IW'(`PAO_IDX_CORE));

  always_comb
  begin
    aw_hold_nxt = aw_hold_r;
    waddr_nxt = waddr_r;
    w_hold_nxt = w_hold_r;
    wdata_nxt = wdata_r;
    wlane_nxt = wlane_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    if (awvalid && awready)
    begin
      aw_hold_nxt = 1'b1;
      waddr_nxt = awaddr[AW-1:2];
    end
    if (wvalid && wready)
    begin
      w_hold_nxt = 1'b1;
      wdata_nxt = wdata[7:0];
      wlane_nxt = wstrb[0];
    end
    if (do_write)
    begin
      aw_hold_nxt = 1'b0;
      w_hold_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = wr_hit ? `PAO_RESP_OK : `PAO_RESP_ERR;
    end
    if (bvalid_r && bready)
      bvalid_nxt = 1'b0;
  end

  always_comb
  begin
    rvalid_nxt = rvalid_r;
    rresp_nxt = rresp_r;
    rdata_nxt = rdata_r;
    if (rvalid_r && rready)
      rvalid_nxt = 1'b0;
    if (arvalid && arready)
    begin
      rvalid_nxt = 1'b1;
      rresp_nxt = rd_hit ? `PAO_RESP_OK : `PAO_RESP_ERR;
      case (rd_idx)
        IW'(`PAO_IDX_PIN): rdata_nxt = pin_level;
        IW'(`PAO_IDX_DIR): rdata_nxt = dir_r;
        IW'(`PAO_IDX_LATCH): rdata_nxt = latch_r;
        IW'(`PAO_IDX_CORE): rdata_nxt = core_r;
        default: rdata_nxt = 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Writing ones to the pin register flips the matching latch bits.
  always_comb
  begin
    dir_nxt = dir_r;
    latch_nxt = latch_r;
    core_nxt = core_r;
    if (do_write && wr_lane)
    begin
      case (wr_idx)
        IW'(`PAO_IDX_PIN): latch_nxt = latch_r ^ wr_dat;
        IW'(`PAO_IDX_DIR): dir_nxt = wr_dat;
        IW'(`PAO_IDX_LATCH): latch_nxt = wr_dat;
        IW'(`PAO_IDX_CORE): core_nxt = wr_dat & `PAO_CORE_MASK;
        default: dir_nxt = dir_r;
      endcase
    end
    latch_nxt = latch_nxt ^ ovr.tog_en;
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    ovr = '0;
    // Pins 7 to 3 keep pull, direction, value and toggle under register control.
    for (int i = 4; i < 8; i++)
    begin
      ovr.ie_en[i] = (pin_change_mask[i] & pin_change_irq_en) | analog_digital_off[i];
      ovr.ie_val[i] = analog_digital_off[i];
    end
    ovr.ie_en[3] = pin_change_mask[3] & pin_change_irq_en;
    ovr.dir_en[2] = serial_ctrl.two_wire & serial_ctrl.pos_sel;
    ovr.dir_val[2] = (serial_ctrl.clock_hold | latch_r[2]) & dir_r[2] & serial_ctrl.pos_sel;
    ovr.val_en[2] = serial_ctrl.two_wire & dir_r[2];
    ovr.tog_en[2] = serial_ctrl.toggle_req & serial_ctrl.pos_sel;
    ovr.ie_en[2] = (pin_change_mask[2] & pin_change_irq_en) | ext_irq_one_en |
                   analog_digital_off[2] | (serial_ctrl.start_irq_en & serial_ctrl.pos_sel);
    ovr.ie_val[2] = analog_digital_off[2];
    // Direction of pin 1 stays with the register, so the latch still sets its pull-up.
    ovr.val_en[1] = serial_ctrl.three_wire & serial_ctrl.pos_sel;
    ovr.val_val[1] = serial_ctrl.data_out & serial_ctrl.pos_sel;
    ovr.ie_en[1] = (pin_change_mask[1] & pin_change_irq_en) | analog_digital_off[1];
    ovr.ie_val[1] = analog_digital_off[1];
    ovr.dir_en[0] = serial_ctrl.two_wire & serial_ctrl.pos_sel;
    ovr.dir_val[0] = (serial_ctrl.sda_low | latch_r[0]) & dir_r[0] & serial_ctrl.pos_sel;
    ovr.val_en[0] = serial_ctrl.two_wire & dir_r[0] & serial_ctrl.pos_sel;
    ovr.ie_en[0] = (pin_change_mask[0] & pin_change_irq_en) | analog_digital_off[0] |
                   (serial_ctrl.start_irq_en & serial_ctrl.pos_sel);
    ovr.ie_val[0] = analog_digital_off[0];
  end

  // Pin 0 gets no serial-input override: reception relies on software keeping it an input.
  for (genvar i = 0; i < 8; i++)
  begin : g_pin
    assign dir_c[i] = ovr.dir_en[i] ? ovr.dir_val[i] : dir_r[i];
    assign out_c[i] = ovr.val_en[i] ? ovr.val_val[i] : latch_r[i];
    assign pull_c[i] = !core_r[`PAO_PUD_BIT] &&
                       (ovr.pull_en[i] ? ovr.pull_val[i] : (latch_r[i] && !dir_r[i]));
    assign in_off_c[i] = ovr.ie_en[i] & ovr.ie_val[i];
  end

  assign ref_mask = 8'h01 << `PAO_REF_PIN;

  ////////////////////////////////////////////////////////////////////////////
  // Three stages guard against metastability; a level is taken once stages two and three agree.
  assign agree = ~(s2_r ^ s3_r);
  assign stable_nxt = (agree & s3_r) | (~agree & stable_r);
  assign pin_level = stable_r & ~in_off_c;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_hold_r <= 1'b0;
      waddr_r <= '0;
      w_hold_r <= 1'b0;
      wdata_r <= 8'h00;
      wlane_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= `PAO_RESP_OK;
      rvalid_r <= 1'b0;
      rresp_r <= `PAO_RESP_OK;
      rdata_r <= 8'h00;
      dir_r <= `PAO_DIR_RST;
      latch_r <= `PAO_LATCH_RST;
      core_r <= `PAO_CORE_RST;
      s1_r <= 8'h00;
      s2_r <= 8'h00;
      s3_r <= 8'h00;
      stable_r <= 8'h00;
      pad_out_r <= 8'h00;
      pad_oe_r <= 8'h00;
      pad_pull_r <= 8'h00;
      pc_src_r <= 8'h00;
      cap_r <= 1'b0;
      ext_r <= 1'b0;
      sdi_r <= 1'b0;
      sck_r <= 1'b0;
    end
    else
    begin
      aw_hold_r <= aw_hold_nxt;
      waddr_r <= waddr_nxt;
      w_hold_r <= w_hold_nxt;
      wdata_r <= wdata_nxt;
      wlane_r <= wlane_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      rvalid_r <= rvalid_nxt;
      rresp_r <= rresp_nxt;
      rdata_r <= rdata_nxt;
      dir_r <= dir_nxt;
      latch_r <= latch_nxt;
      core_r <= core_nxt;
      s1_r <= pad_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      stable_r <= stable_nxt;
      pad_out_r <= out_c;
      pad_oe_r <= dir_c & ~(ref_mask & {8{analog_ref_active}});
      pad_pull_r <= pull_c & ~(ref_mask & {8{analog_ref_active}});
      pc_src_r <= pin_level;
      cap_r <= pin_level[4];
      ext_r <= pin_level[2];
      sdi_r <= pin_level[0];
      sck_r <= pin_level[2];
    end
  end

  assign pad_out = pad_out_r;
  assign pad_oe = pad_oe_r;
  assign pad_pullup = pad_pull_r;
  assign pin_change_src = pc_src_r;
  assign capture_input = cap_r;
  assign ext_irq_one = ext_r;
  assign serial_data_in = sdi_r;
  assign serial_clock_pin = sck_r;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  pud_pull_off_a: assert property (core_r[`PAO_PUD_BIT] |=> pad_pullup == 8'h00)
    else $error("pull-up active while globally disabled");
  three_wire_do_a: assert property ((serial_ctrl.three_wire && serial_ctrl.pos_sel && dir_r[1])
    |=> pad_oe[1] && (pad_out[1] == $past(serial_ctrl.data_out)))
    else $error("pin 1 not driven from serial output");
  pin1_pull_a: assert property ((serial_ctrl.three_wire && !dir_r[1] && latch_r[1] &&
    !core_r[`PAO_PUD_BIT] && !analog_ref_active) |=> pad_pullup[1] && !pad_oe[1])
    else $error("pin 1 pull-up lost in serial mode");
  ref_pin_off_a: assert property (analog_ref_active |=> !pad_oe[3] && !pad_pullup[3])
    else $error("reference pin still driven or pulled");
  scl_dir_a: assert property ((serial_ctrl.two_wire && serial_ctrl.pos_sel) |=>
    pad_oe[2] == $past((serial_ctrl.clock_hold | latch_r[2]) & dir_r[2]))
    else $error("clock pin direction override wrong");
  zero_value_a: assert property ((serial_ctrl.two_wire && dir_r[2]) |=> !pad_out[2])
    else $error("clock pin value not forced low");
  sda_dir_a: assert property ((serial_ctrl.two_wire && serial_ctrl.pos_sel) |=>
    pad_oe[0] == $past((serial_ctrl.sda_low | latch_r[0]) & dir_r[0]))
    else $error("data pin direction override wrong");
  capture_path_a: assert property (((pad_in[4] == $past(pad_in[4])) && !in_off_c[4])[*6]
    |-> capture_input == pad_in[4])
    else $error("capture input does not follow pin 4");
  ext_irq_path_a: assert property (((pad_in[2] == $past(pad_in[2])) && !in_off_c[2])[*6]
    |-> ext_irq_one == pad_in[2])
    else $error("external interrupt does not follow pin 2");
  dir_reset_a: assert property ($rose(aresetn) |-> dir_r == 8'h00 ##1 pad_oe == 8'h00)
    else $error("direction not cleared by reset");
  pin_read_a: assert property ((arvalid && arready && rd_idx == IW'(`PAO_IDX_PIN)) |=>
    rvalid && rdata[7:0] == $past(pin_level))
    else $error("pin register read wrong");

  write_done_c: cover property (do_write ##1 bvalid && bready);
  read_done_c: cover property (arvalid && arready ##1 rvalid && rready);
  two_wire_c: cover property (serial_ctrl.two_wire && serial_ctrl.pos_sel && dir_r[0]);
  toggle_c: cover property (ovr.tog_en[2] ##1 $changed(latch_r[2]));

endmodule // pao_port_a
`default_nettype wire

// File: verification/pao_board.sv
`default_nettype none
module pao_board
(
  input wire logic aclk,
  input wire logic [7:0] pad_out,
  input wire logic [7:0] pad_oe,
  input wire logic [7:0] pad_pullup,
  input wire logic [7:0] ext_val,
  input wire logic [7:0] ext_en,
  output logic [7:0] pad_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] float_r = 8'h55;
  // A pin nobody drives and nothing pulls wanders every cycle, so a stale level never passes.
  always @(posedge aclk)
  begin
    float_r <= ~float_r;
  end
  assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_en & ext_val) |
    (~pad_oe & ~ext_en & (pad_pullup | float_r));
endmodule // pao_board
`default_nettype wire

// File: verification/tb_port_a_pin_override_logic.sv
`include "pao_cfg.svh"
`default_nettype none
module tb_port_a_pin_override_logic
  import pao_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk = 1'h0, aresetn = 1'h0, awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
  logic arvalid = 1'h0, rready = 1'h0, pin_change_irq_en = 1'h0, ext_irq_one_en = 1'h0;
  logic analog_ref_active = 1'h0;
  logic [9:0] awaddr = 10'h0, araddr = 10'h0;
  logic [31:0] wdata = 32'h0, rdata, lfsr = 32'h4bf7;
  logic [7:0] pin_change_mask = 8'h0, analog_digital_off = 8'h0, ext_val = 8'h0, ext_en = 8'h0;
  logic [7:0] pad_in, pad_out, pad_oe, pad_pullup, pin_change_src;
  logic awready, wready, bvalid, arready, rvalid, capture_input, ext_irq_one;
  logic serial_data_in, serial_clock_pin;
  logic [1:0] bresp, rresp;
  logic [3:0] wstrb = 4'hf;
  pao_serial_t sc = '0;
  logic [33:0] exp_q[$];
  int err_count = 0, tests_run = 0, cyc = 0;
  //////////////////////////////////////////////////////////////////////////////
  pao_port_a #(.AW(10)) dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
    .pad_pullup(pad_pullup), .serial_ctrl(sc), .pin_change_mask(pin_change_mask),
    .pin_change_irq_en(pin_change_irq_en), .ext_irq_one_en(ext_irq_one_en),
    .analog_digital_off(analog_digital_off), .analog_ref_active(analog_ref_active),
    .pin_change_src(pin_change_src), .capture_input(capture_input),
    .ext_irq_one(ext_irq_one), .serial_data_in(serial_data_in),
    .serial_clock_pin(serial_clock_pin));
  pao_board board (.aclk(aclk), .pad_out(pad_out), .pad_oe(pad_oe), .pad_pullup(pad_pullup),
    .ext_val(ext_val), .ext_en(ext_en), .pad_in(pad_in));
  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    forever #25 aclk = ~aclk;
  end
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic end_sim();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic cmp_pin(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp_bus(input logic [33:0] got, input logic [33:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Handshakes are judged mid-cycle, where the ready and valid lines are settled.
  always @(negedge aclk)
  begin
    if (aresetn === 1'h1 && bvalid === 1'h1 && bready === 1'h1)
      cmp_bus({bresp, 32'h0}, exp_q.pop_front());
    if (aresetn === 1'h1 && rvalid === 1'h1 && rready === 1'h1)
      cmp_bus({rresp, rdata}, exp_q.pop_front());
  end
  always @(posedge aclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_count++;
      end_sim();
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] rs);
    logic ha, hw, hb;
    exp_q.push_back({rs, 32'h0});
    @(posedge aclk);
    awaddr <= {idx, 2'h0};
    wdata <= {24'h0, d};
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    hb = 1'h0;
    while (!hb)
    begin
      @(negedge aclk);
      ha = awvalid & awready;
      hw = wvalid & wready;
      hb = bvalid;
      @(posedge aclk);
      if (ha)
        awvalid <= 1'h0;
      if (hw)
        wvalid <= 1'h0;
      if (hb)
        bready <= 1'h0;
    end
  endtask
  task automatic rd(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] rs);
    logic ha, hr;
    exp_q.push_back({rs, 24'h0, d});
    @(posedge aclk);
    araddr <= {idx, 2'h0};
    arvalid <= 1'h1;
    rready <= 1'h1;
    hr = 1'h0;
    while (!hr)
    begin
      @(negedge aclk);
      ha = arvalid & arready;
      hr = rvalid;
      @(posedge aclk);
      if (ha)
        arvalid <= 1'h0;
      if (hr)
        rready <= 1'h0;
    end
  endtask
  task automatic st(input int n);
    repeat (n) @(posedge aclk);
    @(negedge aclk);
  endtask
  task automatic set_sc(input logic [7:0] v);
    @(posedge aclk);
    sc <= pao_serial_t'(v);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'h1;
    rd(`PAO_IDX_DIR, `PAO_DIR_RST, `PAO_RESP_OK);
    rd(`PAO_IDX_LATCH, `PAO_LATCH_RST, `PAO_RESP_OK);
    rd(`PAO_IDX_CORE, `PAO_CORE_RST, `PAO_RESP_OK);
    rd(8'h20, 8'h00, `PAO_RESP_ERR);
    wr(8'h20, 8'h5a, `PAO_RESP_ERR);
    wr(`PAO_IDX_DIR, 8'ha5, `PAO_RESP_OK);
    // A write with the low byte lane off must be answered but change nothing.
    @(posedge aclk);
    wstrb <= 4'h0;
    wr(`PAO_IDX_DIR, 8'h3c, `PAO_RESP_OK);
    rd(`PAO_IDX_DIR, 8'ha5, `PAO_RESP_OK);
    @(posedge aclk);
    wstrb <= 4'hf;
    aresetn <= 1'h0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    rd(`PAO_IDX_DIR, `PAO_DIR_RST, `PAO_RESP_OK);
    wr(`PAO_IDX_CORE, 8'hff, `PAO_RESP_OK);
    rd(`PAO_IDX_CORE, 8'h78, `PAO_RESP_OK);
    wr(`PAO_IDX_DIR, 8'h00, `PAO_RESP_OK);
    wr(`PAO_IDX_LATCH, 8'h02, `PAO_RESP_OK);
    st(2);
    cmp_pin(pad_pullup, 8'h00);
    wr(`PAO_IDX_CORE, 8'h00, `PAO_RESP_OK);
    set_sc(8'h64);
    st(2);
    cmp_pin(pad_pullup, 8'h02);
    cmp_pin(pad_oe, 8'h00);
    wr(`PAO_IDX_DIR, 8'h02, `PAO_RESP_OK);
    wr(`PAO_IDX_LATCH, 8'h00, `PAO_RESP_OK);
    st(2);
    cmp_pin(pad_out & 8'h02, 8'h02);
    cmp_pin(pad_oe, 8'h02);
    set_sc(8'h60);
    st(2);
    cmp_pin(pad_out & 8'h02, 8'h00);
    set_sc(8'h00);
    wr(`PAO_IDX_DIR, 8'h08, `PAO_RESP_OK);
    wr(`PAO_IDX_LATCH, 8'h08, `PAO_RESP_OK);
    st(2);
    cmp_pin(pad_oe & pad_out, 8'h08);
    @(posedge aclk);
    analog_ref_active <= 1'h1;
    st(2);
    cmp_pin(pad_oe, 8'h00);
    wr(`PAO_IDX_DIR, 8'h00, `PAO_RESP_OK);
    st(2);
    cmp_pin(pad_pullup, 8'h00);
    @(posedge aclk);
    analog_ref_active <= 1'h0;
    st(2);
    cmp_pin(pad_pullup, 8'h08);
    wr(`PAO_IDX_LATCH, 8'h00, `PAO_RESP_OK);
    wr(`PAO_IDX_DIR, 8'h05, `PAO_RESP_OK);
    set_sc(8'ha0);
    st(2);
    cmp_pin(pad_oe, 8'h00);
    set_sc(8'hb2);
    st(2);
    cmp_pin(pad_oe, 8'h05);
    cmp_pin(pad_out & 8'h05, 8'h00);
    set_sc(8'h00);
    wr(`PAO_IDX_LATCH, 8'h05, `PAO_RESP_OK);
    set_sc(8'ha0);
    st(2);
    cmp_pin(pad_oe, 8'h05);
    cmp_pin(pad_out & 8'h05, 8'h00);
    // A single cycle of toggle request must flip the clock pin latch exactly once.
    set_sc(8'h28);
    set_sc(8'h20);
    rd(`PAO_IDX_LATCH, 8'h01, `PAO_RESP_OK);
    // Three-wire reception stays on from here, so pin 0 must remain an input.
    set_sc(8'h61);
    wr(`PAO_IDX_DIR, 8'h00, `PAO_RESP_OK);
    wr(`PAO_IDX_PIN, 8'h81, `PAO_RESP_OK);
    rd(`PAO_IDX_LATCH, 8'h80, `PAO_RESP_OK);
    wr(`PAO_IDX_LATCH, 8'h00, `PAO_RESP_OK);
    repeat (3)
    begin
      lfsr = lfsr_next(lfsr);
      @(posedge aclk);
      ext_val <= lfsr[7:0];
      ext_en <= 8'hff;
      st(8);
      cmp_pin(pin_change_src, lfsr[7:0]);
      cmp_pin({4'h0, capture_input, ext_irq_one, serial_data_in, serial_clock_pin},
        {4'h0, lfsr[4], lfsr[2], lfsr[0], lfsr[2]});
      rd(`PAO_IDX_PIN, lfsr[7:0], `PAO_RESP_OK);
    end
    @(posedge aclk);
    pin_change_mask <= 8'hff;
    pin_change_irq_en <= 1'h1;
    ext_irq_one_en <= 1'h1;
    st(3);
    cmp_pin(pin_change_src, lfsr[7:0]);
    @(posedge aclk);
    analog_digital_off <= 8'hf5;
    st(3);
    cmp_pin(pin_change_src, lfsr[7:0] & 8'h0a);
    end_sim();
  end
endmodule // tb_port_a_pin_override_logic
`default_nettype wire
